// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic start_in = 1'b0;
  xlb_pkg::xlb_req_t req_in = '0;
  logic [7:0] rdata, wdata, acc;
  logic busy, done, rd, wr, acc_we, z_we, z, c_we, c;
  logic [15:0] addr;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_done = 0;
  int n_ops = 0;
  always #5 mclk_in = ~mclk_in;
  xlb_core DUT (.mclk_in(mclk_in), .resetn_in(resetn_in), .start_in(start_in),
    .req_in(req_in), .mem_rdata_in(rdata), .busy_out(busy), .done_out(done),
    .mem_addr_out(addr), .mem_rd_out(rd), .mem_wr_out(wr), .mem_wdata_out(wdata),
    .acc_we_out(acc_we), .acc_out(acc), .z_we_out(z_we), .z_out(z),
    .c_we_out(c_we), .c_out(c));
  xlb_mem_model mem_m (.mclk_in(mclk_in), .rd_in(rd), .wr_in(wr), .addr_in(addr),
    .wdata_in(wdata), .rdata_out(rdata));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One operation; hold keeps start up an extra edge, which busy must swallow
  task automatic run_op(input logic [2:0] op, input logic hold);
    xlb_pkg::xlb_req_t r;
    logic [7:0] m, res;
    logic acc_e, wr_e, z_e, c_e, cv;
    int k, sum;
    m = 8'($urandom);
    r.op = xlb_pkg::xlb_op_t'(op);
    r.addr = 16'($urandom);
    r.bit_sel = 3'($urandom);
    r.acc = 8'($urandom);
    r.carry = 1'($urandom);
    r.half_byte_overflow_bit = 1'($urandom);
    mem_m.mem[r.addr] = m;
    // Reference behaviour worked out from the operation table
    {acc_e, wr_e, z_e, c_e} = 4'h0;
    res = 8'h00;
    cv = r.carry;
    case (op)
      3'd0: begin res = r.acc & m; acc_e = 1'b1; z_e = 1'b1; end
      3'd1: begin res = r.acc & m; wr_e = 1'b1; z_e = 1'b1; end
      3'd2: begin res = 8'h00; wr_e = 1'b1; end
      3'd3: begin res = m & ~(8'h01 << r.bit_sel); wr_e = 1'b1; end
      3'd4: begin res = ~m; wr_e = 1'b1; z_e = 1'b1; end
      3'd5: begin res = ~m; acc_e = 1'b1; z_e = 1'b1; end
      3'd6: begin
        sum = r.acc;
        if (r.acc[3:0] > 9 || r.half_byte_overflow_bit) sum += 6;
        if (r.acc[7:4] > 9 || r.carry) sum += 96;
        res = sum[7:0];
        cv = r.carry | (sum > 255);
        wr_e = 1'b1;
        c_e = 1'b1;
      end
      default: res = 8'h00;
    endcase
    @(posedge mclk_in);
    start_in <= 1'b1;
    req_in <= r;
    n_ops++;
    @(posedge mclk_in);
    start_in <= hold;
    @(posedge mclk_in);
    start_in <= 1'b0;
    for (k = 0; k < 8 && done !== 1'b1; k++) begin
      @(posedge mclk_in);
      #1;
    end
    chk("latency", 16'd1, 16'(k));
    chk("busy", 16'd0, {15'd0, busy});
    chk("mem_addr", r.addr, addr);
    chk("acc_we", {15'd0, acc_e}, {15'd0, acc_we});
    if (acc_e) chk("acc", {8'd0, res}, {8'd0, acc});
    chk("mem_wr", {15'd0, wr_e}, {15'd0, wr});
    if (wr_e) chk("wdata", {8'd0, res}, {8'd0, wdata});
    chk("z_we", {15'd0, z_e}, {15'd0, z_we});
    if (z_e) chk("z", {15'd0, res == 8'h00}, {15'd0, z});
    chk("c_we", {15'd0, c_e}, {15'd0, c_we});
    if (c_e) chk("c", {15'd0, cv}, {15'd0, c});
    @(posedge mclk_in);
    #1;
    chk("mem byte", {8'd0, wr_e ? res : m}, {8'd0, mem_m.mem[r.addr]});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling sized well above 308 operations of a few cycles each
  always @(posedge mclk_in) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h177F));
    repeat (20) @(posedge mclk_in);
    resetn_in <= 1'b1;
    // Every code once, the unused one included, then a random mix
    for (int i = 0; i < 8; i++) run_op(3'(i), 1'b0);
    for (int i = 0; i < 300; i++) run_op(3'($urandom_range(6, 0)), 1'($urandom));
    repeat (3) @(posedge mclk_in);
    chk("done count", 16'(n_ops), 16'(n_done));
    wrap_up();
  end
endmodule

// >>> dv/xlb_mem_model.sv
`timescale 1ns/1ps
module xlb_mem_model (
  input wire logic mclk_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [xlb_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  initial rdata_out = 8'h5A;
  //////////////////////////////////////////////////////////////////////////////
  // Answers the cycle after a read strobe; data lines churn between answers
  // so a byte taken one cycle late reads inverted rather than passing for a fresh one
  always @(posedge mclk_in) begin
    if (rd_in === 1'b1) begin
      rdata_out <= mem[addr_in];
    end else begin
      rdata_out <= ~rdata_out;
    end
    if (wr_in === 1'b1) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule

// >>> rtl/xlb_core.sv
`timescale 1ns/1ps
module xlb_core (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire xlb_pkg::xlb_req_t req_in,
  input wire logic [7:0] mem_rdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [xlb_pkg::ADDR_W-1:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic acc_we_out,
  output logic [7:0] acc_out,
  output logic z_we_out,
  output logic z_out,
  output logic c_we_out,
  output logic c_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_zero(input logic [7:0] v);
    return v == xlb_pkg::ZERO_BYTE;
  endfunction

  // Returns {carry out, adjusted byte}
  function automatic logic [8:0] dec_adj(input logic [7:0] a, input logic c,
                                         input logic ac);
    logic [7:0] cor;
    cor = xlb_pkg::ZERO_BYTE;
    if (a[3:0] > xlb_pkg::NIB_MAX || ac) begin
      cor = cor | xlb_pkg::COR_LO;
    end
    if (a[7:4] > xlb_pkg::NIB_MAX || c) begin
      cor = cor | xlb_pkg::COR_HI;
    end
    return {1'b0, a} + {1'b0, cor};
  endfunction

  xlb_pkg::xlb_state_t st_r;
  xlb_pkg::xlb_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Read, capture, then commit; strobes last one cycle
  always_comb begin
    logic [7:0] d;
    logic [8:0] adj;
    d = mem_rdata_in;
    adj = dec_adj(st_r.req.acc, st_r.req.carry, st_r.req.half_byte_overflow_bit);
    st_nxt = st_r;
    st_nxt.mem_rd = 1'b0;
    st_nxt.mem_wr = 1'b0;
    st_nxt.acc_we = 1'b0;
    st_nxt.z_we = 1'b0;
    st_nxt.c_we = 1'b0;
    st_nxt.done = 1'b0;
    unique case (st_r.fsm)
      xlb_pkg::S_IDLE: begin
        // Requests while busy are ignored; the decoder waits for done
        if (start_in) begin
          st_nxt.req = req_in;
          st_nxt.busy = 1'b1;
          st_nxt.mem_rd = 1'b1;
          st_nxt.fsm = xlb_pkg::S_READ;
        end
      end
      xlb_pkg::S_READ: begin
        st_nxt.fsm = xlb_pkg::S_CAPT;
      end
      xlb_pkg::S_CAPT: begin
        st_nxt.data = d;
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
        st_nxt.fsm = xlb_pkg::S_IDLE;
        unique case (st_r.req.op)
          xlb_pkg::far_and_to_accum: begin
            st_nxt.acc_o = st_r.req.acc & d;
            st_nxt.acc_we = 1'b1;
            st_nxt.z_we = 1'b1;
            st_nxt.z_o = is_zero(st_r.req.acc & d);
          end
          xlb_pkg::far_and_to_memory: begin
            st_nxt.wdata = st_r.req.acc & d;
            st_nxt.mem_wr = 1'b1;
            st_nxt.z_we = 1'b1;
            st_nxt.z_o = is_zero(st_r.req.acc & d);
          end
          xlb_pkg::far_clear_byte: begin
            st_nxt.wdata = xlb_pkg::ZERO_BYTE;
            st_nxt.mem_wr = 1'b1;
          end
          xlb_pkg::far_clear_bit: begin
            st_nxt.wdata = d & ~(xlb_pkg::ONE_BIT << st_r.req.bit_sel);
            st_nxt.mem_wr = 1'b1;
          end
          xlb_pkg::far_invert_byte: begin
            st_nxt.wdata = ~d;
            st_nxt.mem_wr = 1'b1;
            st_nxt.z_we = 1'b1;
            st_nxt.z_o = is_zero(~d);
          end
          xlb_pkg::far_invert_to_accum: begin
            st_nxt.acc_o = ~d;
            st_nxt.acc_we = 1'b1;
            st_nxt.z_we = 1'b1;
            st_nxt.z_o = is_zero(~d);
          end
          xlb_pkg::far_decimal_adjust: begin
            // carry only; a set carry is never cleared here
            st_nxt.wdata = adj[7:0];
            st_nxt.mem_wr = 1'b1;
            st_nxt.c_we = 1'b1;
            st_nxt.c_o = st_r.req.carry | adj[8];
          end
          default: begin
            // Unused code: no write, only done
          end
        endcase
      end
      default: begin
        st_nxt.fsm = xlb_pkg::S_IDLE;
        st_nxt.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output straight from the state register
  assign busy_out = st_r.busy;
  assign done_out = st_r.done;
  assign mem_addr_out = st_r.req.addr;
  assign mem_rd_out = st_r.mem_rd;
  assign mem_wr_out = st_r.mem_wr;
  assign mem_wdata_out = st_r.wdata;
  assign acc_we_out = st_r.acc_we;
  assign acc_out = st_r.acc_o;
  assign z_we_out = st_r.z_we;
  assign z_out = st_r.z_o;
  assign c_we_out = st_r.c_we;
  assign c_out = st_r.c_o;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  logic [7:0] diff;
  logic [7:0] zres;
  assign diff = mem_wdata_out - st_r.req.acc;
  assign zres = acc_we_out ? acc_out : mem_wdata_out;

  function automatic logic is_op(input xlb_pkg::xlb_op_t o, input xlb_pkg::xlb_op_t w);
    return o == w;
  endfunction

  a_and_accum: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_and_to_accum)
    |-> acc_we_out && acc_out == (st_r.req.acc & st_r.data) && z_we_out && !c_we_out
        && !mem_wr_out) else $error("and to accumulator wrong");
  a_and_mem: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_and_to_memory)
    |-> mem_wr_out && mem_wdata_out == (st_r.req.acc & st_r.data) && !acc_we_out
        && z_we_out && !c_we_out) else $error("and to memory wrong");
  a_clear_byte: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_clear_byte)
    |-> mem_wr_out && mem_wdata_out == 8'h00 && !z_we_out && !c_we_out && !acc_we_out)
    else $error("clear byte wrong");
  a_clear_bit: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_clear_bit)
    |-> mem_wr_out && !mem_wdata_out[st_r.req.bit_sel] && !z_we_out && !c_we_out
        && ((mem_wdata_out ^ st_r.data) & ~(8'h01 << st_r.req.bit_sel)) == 8'h00)
    else $error("clear bit wrong");
  a_inv_mem: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_invert_byte)
    |-> mem_wr_out && (mem_wdata_out ^ st_r.data) == 8'hFF && z_we_out && !acc_we_out)
    else $error("invert byte wrong");
  a_inv_accum: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_invert_to_accum)
    |-> acc_we_out && (acc_out ^ st_r.data) == 8'hFF && !mem_wr_out && z_we_out)
    else $error("invert to accumulator wrong");
  a_adj_low: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_decimal_adjust)
    |-> (diff[3:0] == 4'h6) == (st_r.req.acc[3:0] > 4'h9 || st_r.req.half_byte_overflow_bit))
    else $error("low nibble adjust wrong");
  a_adj_high: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_decimal_adjust)
    |-> (diff[7:4] == 4'h6) == (st_r.req.acc[7:4] > 4'h9 || st_r.req.carry))
    else $error("high nibble adjust wrong");
  a_adj_set: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_decimal_adjust)
    |-> mem_wr_out && diff inside {8'h00, 8'h06, 8'h60, 8'h66})
    else $error("adjust correction wrong");
  a_adj_flags: assert property (done_out && is_op(st_r.req.op, xlb_pkg::far_decimal_adjust)
    |-> c_we_out && !z_we_out && !acc_we_out
        && c_out == (st_r.req.carry || ({1'b0, st_r.req.acc} + {1'b0, diff}) > 9'h0FF))
    else $error("adjust carry wrong");
  a_far_addr: assert property (start_in && !busy_out
    |-> ##1 mem_rd_out && mem_addr_out == $past(req_in.addr) ##1 !mem_rd_out ##1 done_out
        && mem_addr_out == $past(req_in.addr, 3)) else $error("far address wrong");
  a_zero_flag: assert property (z_we_out |-> done_out && z_out == (zres == 8'h00))
    else $error("zero flag wrong");

  c_and_mem: cover property (done_out && mem_wr_out && z_out);
  c_clear_bit: cover property (done_out && is_op(st_r.req.op, xlb_pkg::far_clear_bit));
  c_adj_both: cover property (done_out && c_we_out && diff == 8'h66);
  c_back_to_back: cover property (done_out && start_in);

endmodule

// >>> rtl/xlb_pkg.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package xlb_pkg;

  localparam int ADDR_W = 16;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BIT = 8'h01;
  localparam logic [3:0] NIB_MAX = 4'h9;
  localparam logic [7:0] COR_LO = 8'h06;
  localparam logic [7:0] COR_HI = 8'h60;
  localparam int READ_LAT = 1; // Memory answers the cycle after the read strobe

  typedef enum logic [2:0] {
    far_and_to_accum,
    far_and_to_memory,
    far_clear_byte,
    far_clear_bit,
    far_invert_byte,
    far_invert_to_accum,
    far_decimal_adjust
  } xlb_op_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_READ,
    S_CAPT
  } xlb_fsm_t;

  // Request from the decoder, with the core's current operands
  typedef struct packed {
    xlb_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] acc;
    logic carry;
    logic half_byte_overflow_bit;
  } xlb_req_t;

  typedef struct packed {
    xlb_fsm_t fsm;
    logic busy;
    xlb_req_t req;
    logic [7:0] data;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] wdata;
    logic acc_we;
    logic [7:0] acc_o;
    logic z_we;
    logic z_o;
    logic c_we;
    logic c_o;
    logic done;
  } xlb_state_t;

endpackage
